/* File: common/trl_pkg.sv */
package trl_pkg;

	// Result and limit widths
	localparam int RES_W    = 10;
	localparam int LIM_W    = 8;
	localparam int NUM_CH   = 3;
	localparam int AVG_LOG2 = 4;

	// Channel indices
	localparam int CH_VDD = 0;
	localparam int CH_INT = 1;
	localparam int CH_EXT = 2;

	// Register offsets
	localparam logic [7:0] ADDR_FLAGS_A = 8'h00;
	localparam logic [7:0] ADDR_FLAGS_B = 8'h01;
	localparam logic [7:0] ADDR_LOW_A   = 8'h03;
	localparam logic [7:0] ADDR_LOW_B   = 8'h04;
	localparam logic [NUM_CH-1:0][7:0] ADDR_MSB    = {8'h08, 8'h07, 8'h06};
	localparam logic [NUM_CH-1:0][7:0] ADDR_LIM_HI = {8'h27, 8'h25, 8'h23};
	localparam logic [NUM_CH-1:0][7:0] ADDR_LIM_LO = {8'h28, 8'h26, 8'h24};
	localparam logic [1:0][7:0]        ADDR_MASK   = {8'h1E, 8'h1D};
	localparam logic [1:0][7:0]        ADDR_OFS    = {8'h20, 8'h1F};

	// Values after reset
	localparam logic [NUM_CH-1:0][7:0] RST_LIM_HI = {8'hFF, 8'h64, 8'hC7};
	localparam logic [NUM_CH-1:0][7:0] RST_LIM_LO = {8'h00, 8'hC9, 8'h62};

	// Flag positions in the 16-bit pair {flags_b, flags_a}
	localparam logic [NUM_CH-1:0][3:0] POS_HI    = {4'h2, 4'h0, 4'hC};
	localparam logic [NUM_CH-1:0][3:0] POS_LO    = {4'h3, 4'h1, 4'hD};
	localparam logic [3:0]             POS_FAULT = 4'h4;

	// Averager states
	typedef enum logic [1:0] {
		TRL_RUN  = 2'b01,
		TRL_HOLD = 2'b10
	} trl_avg_state_e;

endpackage

/* File: common/trl_chan_if.sv */
`timescale 1ns/10ps
interface trl_chan_if;
	logic                      smp_valid;
	logic [trl_pkg::RES_W-1:0] smp_data;
	logic                      abort;
	logic                      done;
	logic [trl_pkg::RES_W-1:0] avg;

	modport host (output smp_valid, output smp_data, output abort, input done, input avg);
	modport chan (input smp_valid, input smp_data, input abort, output done, output avg);
endinterface

/* File: rtl/trl_avg.sv */
`timescale 1ns/10ps
module trl_avg #(
	parameter int AVG_LOG2 = trl_pkg::AVG_LOG2
) (
	// Clock and reset
	input  wire logic  clk_in,
	input  wire logic  rstn_in,
	// Channel link
	trl_chan_if.chan   ch
);
	localparam int ACC_W = trl_pkg::RES_W + AVG_LOG2;

	trl_pkg::trl_avg_state_e     state;
	trl_pkg::trl_avg_state_e     next_state;
	logic signed [ACC_W-1:0]     acc;
	logic signed [ACC_W-1:0]     next_acc;
	logic signed [ACC_W-1:0]     sum;
	logic [AVG_LOG2-1:0]         cnt;
	logic [AVG_LOG2-1:0]         next_cnt;
	logic                        done;
	logic                        next_done;
	logic [trl_pkg::RES_W-1:0]   avg;
	logic [trl_pkg::RES_W-1:0]   next_avg;

	always_comb begin
		next_state = state;
		next_acc   = acc;
		next_cnt   = cnt;
		next_done  = 1'b0;
		next_avg   = avg;
		sum        = acc + ACC_W'($signed(ch.smp_data));
		unique case (state)
			trl_pkg::TRL_RUN: begin
				if (ch.abort) begin
					// Partial sum is dropped, restart from zero afterwards
					next_state = trl_pkg::TRL_HOLD;
					next_acc   = '0;
					next_cnt   = '0;
				end else if (ch.smp_valid) begin
					if (cnt == '1) begin
						next_avg  = sum[ACC_W-1:AVG_LOG2];
						next_done = 1'b1;
						next_acc  = '0;
						next_cnt  = '0;
					end else begin
						next_acc = sum;
						next_cnt = cnt + 1'b1;
					end
				end
			end
			trl_pkg::TRL_HOLD: begin
				if (!ch.abort) begin
					next_state = trl_pkg::TRL_RUN;
				end
			end
			default: begin
				next_state = trl_pkg::TRL_HOLD;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= trl_pkg::TRL_RUN;
			acc   <= '0;
			cnt   <= '0;
			done  <= 1'b0;
			avg   <= '0;
		end else begin
			state <= next_state;
			acc   <= next_acc;
			cnt   <= next_cnt;
			done  <= next_done;
			avg   <= next_avg;
		end
	end

	assign ch.done = done;
	assign ch.avg  = avg;

	a_avg_full_block: assert property (@(posedge clk_in) disable iff (!rstn_in)
		ch.done |-> $past(cnt) == '1 && $past(ch.smp_valid) && !$past(ch.abort))
		else $error("average done without a full block");

	a_abort_clears: assert property (@(posedge clk_in) disable iff (!rstn_in)
		ch.abort |=> cnt == '0 && !ch.done && state == trl_pkg::TRL_HOLD)
		else $error("abort did not clear the averager");

endmodule // trl_avg

/* File: rtl/trl_readout.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - Temperature results are two's complement
// - Offset registers added before storing temperature results
// - Each result averages sixteen samples
// - External result is 10-bit two's complement
// - One step is a quarter degree
// - Both temperature channels share one coding
// - High is greater-than, low is less-or-equal
// - Limits are 8 bits, results 10
// - Unmasked limit events set status flags
// - Interrupt pin follows flags and polarity
// - Results split into high and low registers
// - Low-bits read freezes linked high registers
// - Reading a frozen high register unfreezes all
// - High-first read freezes no low register
// - No cross-freezing within same register kind
// - Serial activity aborts and restarts conversion
// - Status clears on read once condition gone
module trl_readout #(
	parameter int AVG_LOG2 = trl_pkg::AVG_LOG2
) (
	// Clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rstn_in,
	// Converter samples
	input  wire logic        smp_valid_in,
	input  wire logic [1:0]  smp_chan_in,
	input  wire logic [9:0]  smp_data_in,
	input  wire logic        ext_fault_in,
	// Register access from the serial front end
	input  wire logic        comm_active_in,
	input  wire logic        reg_rd_in,
	input  wire logic        reg_wr_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	output logic      [7:0]  reg_rdata_out,
	// Control and status pins
	input  wire logic        int_active_high_in,
	input  wire logic        soft_reset_in,
	output logic             int_out,
	output logic             adc_reset_out
);
	localparam int NCH = trl_pkg::NUM_CH;

	if (AVG_LOG2 < 1 || AVG_LOG2 > 6) begin : g_bad_avg
		$error("AVG_LOG2 out of range");
	end

	logic                   rst_meta;
	logic                   rst_n;
	logic [1:0][7:0]        mask;
	logic [1:0][7:0]        next_mask;
	logic [1:0][7:0]        ofs;
	logic [1:0][7:0]        next_ofs;
	logic [NCH-1:0][7:0]    lim_hi;
	logic [NCH-1:0][7:0]    next_lim_hi;
	logic [NCH-1:0][7:0]    lim_lo;
	logic [NCH-1:0][7:0]    next_lim_lo;
	logic [NCH-1:0][7:0]    msb;
	logic [NCH-1:0][7:0]    next_msb;
	logic [NCH-1:0][1:0]    lsb;
	logic [NCH-1:0][1:0]    next_lsb;
	logic [NCH-1:0]         lock;
	logic [NCH-1:0]         next_lock;
	logic [15:0]            flags;
	logic [15:0]            next_flags;
	logic [15:0]            cond;
	logic [15:0]            next_cond;
	logic [15:0]            flag_set;
	logic [15:0]            flag_clr;
	logic [7:0]             rdata;
	logic [7:0]             next_rdata;
	logic                   int_q;
	logic                   next_int;
	logic                   adc_rst;
	logic                   next_adc_rst;
	logic [7:0]             rd_val;
	logic [NCH-1:0]         ch_done;
	logic [NCH-1:0][9:0]    ch_avg;
	logic [NCH-1:0][9:0]    res_val;
	logic [NCH-1:0]         hi_hit;
	logic [NCH-1:0]         lo_hit;
	logic [15:0]            mask16;
	logic                   flag_any;
	logic [7:0]             msb_int;

	function automatic logic trl_above(input logic [7:0] a, input logic [7:0] b, input logic sgn);
		trl_above = sgn ? ($signed(a) > $signed(b)) : (a > b);
	endfunction

	// Reset release through two stages
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	for (genvar c = 0; c < NCH; c++) begin : g_ch
		trl_chan_if u_if ();
		assign u_if.smp_valid = smp_valid_in && (smp_chan_in == 2'(c)) && !comm_active_in;
		assign u_if.smp_data  = smp_data_in;
		assign u_if.abort     = comm_active_in;
		assign ch_done[c]     = u_if.done;
		assign ch_avg[c]      = u_if.avg;
		trl_avg #(
			.AVG_LOG2 (AVG_LOG2)
		) u_avg (
			.clk_in  (clk_sys_in),
			.rstn_in (rst_n),
			.ch      (u_if)
		);
	end

	assign mask16   = {mask[1], mask[0]};
	assign flag_any = |(flags & ~mask16);
	assign msb_int  = msb[trl_pkg::CH_INT];

	// Offset and limit comparison; codes stay two's complement
	always_comb begin
		res_val[trl_pkg::CH_VDD] = ch_avg[trl_pkg::CH_VDD];
		res_val[trl_pkg::CH_INT] = ch_avg[trl_pkg::CH_INT] + {{2{ofs[0][7]}}, ofs[0]};
		res_val[trl_pkg::CH_EXT] = ch_avg[trl_pkg::CH_EXT] + {{2{ofs[1][7]}}, ofs[1]};
		for (int c = 0; c < NCH; c++) begin
			// Supply codes are unsigned, temperatures signed
			hi_hit[c] = trl_above(res_val[c][9:2], lim_hi[c], c != trl_pkg::CH_VDD);
			lo_hit[c] = !trl_above(res_val[c][9:2], lim_lo[c], c != trl_pkg::CH_VDD);
		end
	end

	// Read data mux; unmapped offsets read zero
	always_comb begin
		rd_val = 8'h00;
		if (reg_addr_in == trl_pkg::ADDR_FLAGS_A) rd_val = flags[7:0];
		if (reg_addr_in == trl_pkg::ADDR_FLAGS_B) rd_val = flags[15:8];
		if (reg_addr_in == trl_pkg::ADDR_LOW_A) rd_val = {4'h0, lsb[trl_pkg::CH_INT], lsb[trl_pkg::CH_VDD]};
		if (reg_addr_in == trl_pkg::ADDR_LOW_B) rd_val = {6'h00, lsb[trl_pkg::CH_EXT]};
		for (int i = 0; i < 2; i++) begin
			if (reg_addr_in == trl_pkg::ADDR_MASK[i]) rd_val = mask[i];
			if (reg_addr_in == trl_pkg::ADDR_OFS[i]) rd_val = ofs[i];
		end
		for (int c = 0; c < NCH; c++) begin
			if (reg_addr_in == trl_pkg::ADDR_MSB[c]) rd_val = msb[c];
			if (reg_addr_in == trl_pkg::ADDR_LIM_HI[c]) rd_val = lim_hi[c];
			if (reg_addr_in == trl_pkg::ADDR_LIM_LO[c]) rd_val = lim_lo[c];
		end
	end

	always_comb begin
		next_mask    = mask;
		next_ofs     = ofs;
		next_lim_hi  = lim_hi;
		next_lim_lo  = lim_lo;
		next_msb     = msb;
		next_lsb     = lsb;
		next_lock    = lock;
		next_cond    = cond;
		next_rdata   = rdata;
		flag_set     = '0;
		flag_clr     = '0;
		if (reg_wr_in) begin
			for (int i = 0; i < 2; i++) begin
				if (reg_addr_in == trl_pkg::ADDR_MASK[i]) next_mask[i] = reg_wdata_in;
				if (reg_addr_in == trl_pkg::ADDR_OFS[i]) next_ofs[i] = reg_wdata_in;
			end
			for (int c = 0; c < NCH; c++) begin
				if (reg_addr_in == trl_pkg::ADDR_LIM_HI[c]) next_lim_hi[c] = reg_wdata_in;
				if (reg_addr_in == trl_pkg::ADDR_LIM_LO[c]) next_lim_lo[c] = reg_wdata_in;
			end
		end
		for (int c = 0; c < NCH; c++) begin
			if (ch_done[c]) begin
				next_cond[trl_pkg::POS_HI[c]] = hi_hit[c];
				next_cond[trl_pkg::POS_LO[c]] = lo_hit[c];
				flag_set[trl_pkg::POS_HI[c]]  = hi_hit[c] && !mask16[trl_pkg::POS_HI[c]];
				flag_set[trl_pkg::POS_LO[c]]  = lo_hit[c] && !mask16[trl_pkg::POS_LO[c]];
				// Frozen pair keeps the old value; this result is not kept
				if (!lock[c]) begin
					next_msb[c] = res_val[c][9:2];
					next_lsb[c] = res_val[c][1:0];
				end
			end
		end
		next_cond[trl_pkg::POS_FAULT] = ext_fault_in;
		flag_set[trl_pkg::POS_FAULT]  = ext_fault_in && !mask16[trl_pkg::POS_FAULT];
		if (reg_rd_in) begin
			next_rdata = rd_val;
			if (reg_addr_in == trl_pkg::ADDR_LOW_A) begin
				next_lock[trl_pkg::CH_VDD] = 1'b1;
				next_lock[trl_pkg::CH_INT] = 1'b1;
			end
			if (reg_addr_in == trl_pkg::ADDR_LOW_B) next_lock[trl_pkg::CH_EXT] = 1'b1;
			for (int c = 0; c < NCH; c++) begin
				// Unfrozen high read leaves all locks as they are
				if (reg_addr_in == trl_pkg::ADDR_MSB[c] && lock[c]) next_lock = '0;
			end
			if (reg_addr_in == trl_pkg::ADDR_FLAGS_A) flag_clr[7:0] = ~cond[7:0];
			if (reg_addr_in == trl_pkg::ADDR_FLAGS_B) flag_clr[15:8] = ~cond[15:8];
		end
		if (soft_reset_in) flag_clr = '1;
		// New event wins over a clear in the same cycle
		next_flags   = (flags & ~flag_clr) | flag_set;
		next_int     = int_active_high_in ? flag_any : !flag_any;
		next_adc_rst = comm_active_in;
	end

	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			mask    <= '0;
			ofs     <= '0;
			lim_hi  <= trl_pkg::RST_LIM_HI;
			lim_lo  <= trl_pkg::RST_LIM_LO;
			msb     <= '0;
			lsb     <= '0;
			lock    <= '0;
			flags   <= '0;
			cond    <= '0;
			rdata   <= 8'h00;
			int_q   <= 1'b0;
			adc_rst <= 1'b0;
		end else begin
			mask    <= next_mask;
			ofs     <= next_ofs;
			lim_hi  <= next_lim_hi;
			lim_lo  <= next_lim_lo;
			msb     <= next_msb;
			lsb     <= next_lsb;
			lock    <= next_lock;
			flags   <= next_flags;
			cond    <= next_cond;
			rdata   <= next_rdata;
			int_q   <= next_int;
			adc_rst <= next_adc_rst;
		end
	end

	assign reg_rdata_out = rdata;
	assign int_out       = int_q;
	assign adc_reset_out = adc_rst;

	a_int_pin_level: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		##1 int_out == ($past(int_active_high_in) ? $past(flag_any) : !$past(flag_any)))
		else $error("interrupt pin does not follow flags and polarity");

	a_lock_low_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		reg_rd_in && reg_addr_in == trl_pkg::ADDR_LOW_A |=> lock[trl_pkg::CH_VDD] && lock[trl_pkg::CH_INT])
		else $error("low-bits read did not freeze linked registers");

	a_unlock_high_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		reg_rd_in && reg_addr_in == trl_pkg::ADDR_MSB[trl_pkg::CH_VDD] && lock[trl_pkg::CH_VDD] |=> lock == '0)
		else $error("frozen high read did not release all");

	a_high_no_lock: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		reg_rd_in && reg_addr_in == trl_pkg::ADDR_MSB[trl_pkg::CH_INT] && lock == '0 |=> lock == '0)
		else $error("high-first read froze a register");

	a_frozen_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		lock[trl_pkg::CH_INT] && ch_done[trl_pkg::CH_INT] |=> $stable(msb_int))
		else $error("frozen high register changed");

	a_stored_offset: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		ch_done[trl_pkg::CH_INT] && !lock[trl_pkg::CH_INT] |=>
		{msb[trl_pkg::CH_INT], lsb[trl_pkg::CH_INT]} == 10'($past(ch_avg[trl_pkg::CH_INT]) + {{2{$past(ofs[0][7])}}, $past(ofs[0])}))
		else $error("stored result lacks offset");

	a_high_flag_set: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		ch_done[trl_pkg::CH_EXT] && hi_hit[trl_pkg::CH_EXT] && !mask[0][2] |=> flags[2] ##1 int_out == int_active_high_in)
		else $error("unmasked high event not flagged");

	a_flag_clear_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		reg_rd_in && reg_addr_in == trl_pkg::ADDR_FLAGS_A && !cond[0] && !flag_set[0] |=> !flags[0])
		else $error("status not cleared by read");

	a_adc_abort: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		comm_active_in |=> adc_reset_out)
		else $error("converter not reset during communication");

	a_adc_release: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		!comm_active_in |=> !adc_reset_out)
		else $error("converter held in reset after communication");

	a_ext_low_lock: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		reg_rd_in && reg_addr_in == trl_pkg::ADDR_LOW_B |=> lock[trl_pkg::CH_EXT])
		else $error("external low-bits read did not freeze its high register");

	a_no_cross_lock: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		reg_rd_in && reg_addr_in == trl_pkg::ADDR_LOW_B && !lock[trl_pkg::CH_VDD] && !lock[trl_pkg::CH_INT]
		|=> !lock[trl_pkg::CH_VDD] && !lock[trl_pkg::CH_INT])
		else $error("low-bits read froze an unrelated register");

	a_unlock_int_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		reg_rd_in && reg_addr_in == trl_pkg::ADDR_MSB[trl_pkg::CH_INT] && lock[trl_pkg::CH_INT] |=> lock == '0)
		else $error("frozen internal high read did not release all");

	a_low_inclusive: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		ch_done[trl_pkg::CH_INT] && res_val[trl_pkg::CH_INT][9:2] == lim_lo[trl_pkg::CH_INT]
		|-> lo_hit[trl_pkg::CH_INT])
		else $error("result equal to low limit not flagged");

	a_soft_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		soft_reset_in && flag_set == '0 |=> flags == '0)
		else $error("software reset did not clear the status flags");

endmodule // trl_readout

/* File: test/trl_host.sv */
`timescale 1ns/10ps
module trl_host (
	// Clock
	input  wire logic       clk_in,
	// Register access
	output logic            comm_active_out,
	output logic            rd_out,
	output logic            wr_out,
	output logic      [7:0] addr_out,
	output logic      [7:0] wdata_out,
	input  wire logic [7:0] rdata_in
);
	initial begin
		comm_active_out = 1'b0;
		rd_out = 1'b0;
		wr_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 8'h00;
	end
	// One short frame per access; a frame also aborts conversion
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_in) #1;
		comm_active_out = 1'b1;
		rd_out = ~w;
		wr_out = w;
		addr_out = a;
		wdata_out = d;
		@(posedge clk_in) #1;
		q = rdata_in;
		rd_out = 1'b0;
		wr_out = 1'b0;
		// Released bus shows no stale value
		addr_out = ~a;
		wdata_out = ~d;
		comm_active_out = 1'b0;
	endtask
	// Code to quarter degrees
	function automatic int qdeg(input logic [9:0] c);
		return c[9] ? int'(c[8:0]) - 512 : int'(c);
	endfunction
endmodule // trl_host

/* File: test/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	logic       clk_sys_in = 1'b0;
	logic       rstn_in = 1'b0;
	logic       smp_valid_in = 1'b0;
	logic [1:0] smp_chan_in = 2'h0;
	logic [9:0] smp_data_in = 10'h000;
	logic       ext_fault_in = 1'b0;
	logic       int_hi = 1'b1;
	logic       soft_rst = 1'b0;
	logic       comm, rd_s, wr_s, int_out, adc_rst;
	logic [7:0] addr, wdata, rdata;
	int         failures = 0;
	int         tests_run = 0;

	always #2.5 clk_sys_in = ~clk_sys_in;

	// Two samples per average keeps the run short
	trl_readout #(.AVG_LOG2(1)) DUT (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
		.smp_valid_in(smp_valid_in), .smp_chan_in(smp_chan_in), .smp_data_in(smp_data_in),
		.ext_fault_in(ext_fault_in), .comm_active_in(comm), .reg_rd_in(rd_s), .reg_wr_in(wr_s),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.int_active_high_in(int_hi), .soft_reset_in(soft_rst), .int_out(int_out),
		.adc_reset_out(adc_rst));
	trl_host host (.clk_in(clk_sys_in), .comm_active_out(comm), .rd_out(rd_s), .wr_out(wr_s),
		.addr_out(addr), .wdata_out(wdata), .rdata_in(rdata));

	task automatic close_out;
		if (failures == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [9:0] e, input logic [9:0] s);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		host.access(1'b0, a, 8'h00, q);
		chk($sformatf("reg %h", a), {2'b00, e}, {2'b00, q});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		host.access(1'b1, a, d, q);
	endtask
	task automatic s1(input logic [1:0] c, input logic [9:0] v);
		@(posedge clk_sys_in) #1;
		smp_valid_in = 1'b1;
		smp_chan_in = c;
		smp_data_in = v;
		@(posedge clk_sys_in) #1;
		smp_valid_in = 1'b0;
		smp_data_in = ~v;
	endtask
	// Storage after two cycles, pin one cycle later
	task automatic avg2(input logic [1:0] c, input logic [9:0] a, input logic [9:0] b);
		s1(c, a);
		s1(c, b);
		repeat (3) @(posedge clk_sys_in);
		#1;
	endtask

	task automatic t_reset;
		for (int i = 0; i < trl_pkg::NUM_CH; i++) begin
			rd(trl_pkg::ADDR_LIM_HI[i], trl_pkg::RST_LIM_HI[i]);
			rd(trl_pkg::ADDR_LIM_LO[i], trl_pkg::RST_LIM_LO[i]);
		end
		rd(8'h02, 8'h00);
		wr(8'h00, 8'hFF);
		rd(8'h00, 8'h00);
		chk("int_out", 10'h000, {9'h000, int_out});
	endtask
	task automatic t_avg;
		wr(8'h1F, 8'h02);
		avg2(2'd1, 10'h064, 10'h065);
		rd(8'h03, 8'h08);
		rd(8'h07, 8'h19);
		rd(8'h00, 8'h00);
	endtask
	task automatic t_ext;
		avg2(2'd2, 10'h360, 10'h360);
		chk("int_out", 10'h001, {9'h000, int_out});
		rd(8'h04, 8'h00);
		rd(8'h08, 8'hD8);
		chk("qdeg", 10'(-160), 10'(host.qdeg(10'h360)));
		rd(8'h00, 8'h08);
		int_hi = 1'b0;
		repeat (2) @(posedge clk_sys_in);
		#1;
		chk("int_out low", 10'h000, {9'h000, int_out});
		int_hi = 1'b1;
		soft_rst = 1'b1;
		@(posedge clk_sys_in) #1;
		soft_rst = 1'b0;
		repeat (2) @(posedge clk_sys_in);
		#1;
		chk("int_out srst", 10'h000, {9'h000, int_out});
		rd(8'h00, 8'h00);
		wr(8'h1D, 8'h08);
		avg2(2'd2, 10'h360, 10'h360);
		chk("int_out mask", 10'h000, {9'h000, int_out});
		rd(8'h00, 8'h00);
		wr(8'h1D, 8'h00);
		ext_fault_in = 1'b1;
		repeat (3) @(posedge clk_sys_in);
		#1;
		ext_fault_in = 1'b0;
		rd(8'h00, 8'h10);
		rd(8'h00, 8'h00);
		// Positive code above a negative limit only flags when compared signed
		avg2(2'd2, 10'h004, 10'h004);
		chk("int_out ext high", 10'h001, {9'h000, int_out});
		rd(8'h00, 8'h04);
		wr(8'h27, 8'h7F);
		avg2(2'd2, 10'h004, 10'h004);
		rd(8'h00, 8'h04);
		rd(8'h00, 8'h00);
	endtask
	task automatic t_lim;
		wr(8'h25, 8'h19);
		wr(8'h26, 8'h18);
		avg2(2'd1, 10'h064, 10'h065);
		rd(8'h00, 8'h00);
		wr(8'h25, 8'h18);
		wr(8'h26, 8'h19);
		avg2(2'd1, 10'h064, 10'h065);
		rd(8'h00, 8'h03);
		wr(8'h25, 8'h64);
		wr(8'h26, 8'hC9);
		avg2(2'd1, 10'h064, 10'h065);
		rd(8'h00, 8'h03);
		rd(8'h00, 8'h00);
		avg2(2'd0, 10'h190, 10'h190);
		rd(8'h01, 8'h00);
		avg2(2'd0, 10'h188, 10'h188);
		rd(8'h01, 8'h20);
		rd(8'h06, 8'h62);
		rd(8'h03, 8'h08);
	endtask
	// Results finishing while locked are dropped, not delayed
	task automatic t_lock;
		rd(8'h03, 8'h08);
		avg2(2'd1, 10'h000, 10'h000);
		avg2(2'd0, 10'h190, 10'h190);
		rd(8'h06, 8'h62);
		rd(8'h07, 8'h19);
		avg2(2'd1, 10'h000, 10'h000);
		rd(8'h07, 8'h00);
		avg2(2'd0, 10'h190, 10'h190);
		rd(8'h06, 8'h64);
		avg2(2'd0, 10'h3FC, 10'h3FC);
		rd(8'h01, 8'h30);
	endtask
	task automatic t_abort;
		s1(2'd1, 10'h3FE);
		rd(8'h02, 8'h00);
		chk("adc_reset on", 10'h001, {9'h000, adc_rst});
		@(posedge clk_sys_in) #1;
		chk("adc_reset off", 10'h000, {9'h000, adc_rst});
		avg2(2'd1, 10'h010, 10'h012);
		rd(8'h03, 8'h0C);
		rd(8'h07, 8'h04);
	endtask

	initial begin
		#20000;
		failures++;
		close_out();
	end
	initial begin
		repeat (10) @(posedge clk_sys_in);
		#1 rstn_in = 1'b1;
		repeat (3) @(posedge clk_sys_in);
		t_reset();
		t_avg();
		t_ext();
		t_lim();
		t_lock();
		t_abort();
		close_out();
	end
endmodule // tb_top
